// ==== tacpd_defs.svh ====
// Constants and field layouts for the touch converter control block
`ifndef TACPD_DEFS_SVH
`define TACPD_DEFS_SVH

`define TACPD_DIV_SEL_W       2
`define TACPD_DIV_NONE        2'h0
`define TACPD_DIV_TWO         2'h1
`define TACPD_DIV_FOUR        2'h2
`define TACPD_DIV_EIGHT       2'h3
`define TACPD_RES_HI_BITS     12
`define TACPD_RES_LO_BITS     10
`define TACPD_SAMPLE_CYCLES   8'h06
`define TACPD_CHAN_X          3'h0
`define TACPD_CHAN_Y          3'h1
`define TACPD_CHAN_Z1         3'h2
`define TACPD_CHAN_Z2         3'h3
`define TACPD_CHAN_TEMP_SINGLE_DIODE      3'h4
`define TACPD_CHAN_TEMP_RATIO_DIODE      3'h5
`define TACPD_CHAN_AUX        3'h6
`define TACPD_DLY_W           8
`define TACPD_SYNC_RESET      1'h1

`endif

// ==== tacpd_pkg.sv ====
// Types shared by the touch converter control block
package tacpd_pkg;
    typedef enum logic [1:0] {
        TACPD_SCAN_SINGLE,
        TACPD_SCAN_XY,
        TACPD_SCAN_XYZ,
        TACPD_SCAN_TEMP_DIFF
    } tacpd_scan_t;
endpackage

// ==== tacpd_clk_en.sv ====
// Conversion clock enable pulse generator
`timescale 1ns/1ns
`default_nettype none
`include "tacpd_defs.svh"

module tacpd_clk_en (
    input  wire logic       core_clk,           // Internal oscillator
    input  wire logic       reset,              // Synchronous, active high
    input  wire logic [1:0] conv_clock_div_sel, // Divider selection
    output logic            conv_tick           // One-cycle enable pulse
);
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [2:0] limit;
    logic       tick_reg;
    logic       tick_next;

    always_comb begin
        case (conv_clock_div_sel)
            `TACPD_DIV_NONE: limit = 3'h0;
            `TACPD_DIV_TWO:  limit = 3'h1;
            `TACPD_DIV_FOUR: limit = 3'h3;
            default:         limit = 3'h7;
        endcase
        if (cnt_reg >= limit) begin
            cnt_next  = 3'h0;
            tick_next = 1'b1;
        end else begin
            cnt_next  = cnt_reg + 3'h1;
            tick_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            cnt_reg  <= 3'h0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign conv_tick = tick_reg;
endmodule
`default_nettype wire

// ==== tacpd_core.sv ====
// Converter sequencer, result registers and pen-touch detection
// How it works
// - Resolution selects 10 or 12 bit conversion; 10 bit takes fewer steps.
// - Conversion clock is the oscillator divided per the two-bit selection.
// - Selection zero passes the oscillator undivided; only 10 bit is meaningful.
// - Results are unsigned straight binary, zero low, all ones full scale.
// - Each result goes to the register of its measured input.
// - Channel, scan, filter enable, resolution, rate come from control ports.
// - Temperature single diode, or differential adding a second diode conversion.
// - Sampling takes fixed oscillator cycles; stabilization delay comes first.
// - Idle holds Y-minus to ground, low X-plus flags a touch.
// - X and Y measurements disconnect the X-plus pull-up.
// - Touch recheck reconnects pull-up and precharges the panel in the same state, then senses.
// - Precharge and sense times are programmed durations.
// - Status pin shows either result ready or pen touch.
`timescale 1ns/1ns
`default_nettype none
`include "tacpd_defs.svh"

module tacpd_core #(
    parameter int HI_BITS = `TACPD_RES_HI_BITS, // Full resolution
    parameter int LO_BITS = `TACPD_RES_LO_BITS  // Reduced resolution
) (
    input  wire logic                   core_clk,           // Internal oscillator
    input  wire logic                   reset,              // Synchronous, active high
    input  wire logic                   start,              // Begin a scan, one pulse
    input  wire logic [2:0]             chan_sel,           // Channel for single scan
    input  wire logic [1:0]             scan_mode,          // tacpd_scan_t code
    input  wire logic                   filter_en,          // Preprocessing enable
    input  wire logic                   res_low,            // 1 selects 10 bit
    input  wire logic [1:0]             conv_clock_div_sel, // Conversion rate
    input  wire logic [7:0]             stab_dly,           // Panel stabilization cycles
    input  wire logic [7:0]             prechg_dly,         // Precharge cycles
    input  wire logic [7:0]             sense_dly,          // Sense cycles
    input  wire logic                   pin_sel_pen,        // Status pin shows pen touch
    input  wire logic                   result_ack,         // Clears result ready flag
    input  wire logic                   comp_in,            // Comparator from analog
    input  wire logic                   xplus_in,           // X-plus level pin
    output logic                        pull_up_on,         // X-plus pull-up connected
    output logic                        yminus_gnd,         // Y-minus driver to ground
    output logic                        prechg_on,          // Panel precharge drive
    output logic                        sample_on,          // Sample switch closed
    output logic [2:0]                  mux_sel,            // Analog mux channel
    output logic [HI_BITS-1:0]          dac_code,           // Trial code to DAC
    output logic                        filter_on,          // Preprocessing active
    output logic                        busy,               // Sequence in progress
    output logic                        result_ready_flag,  // New result stored
    output logic                        pen_touch_irq,      // Pen touch, active low
    output logic                        irq_status_pin,     // Status pin, active low
    output logic [7*HI_BITS-1:0]        results             // Results by channel
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_STAB, ST_SAMPLE, ST_CONV, ST_STORE, ST_PRECHG, ST_SENSE
    } tacpd_state_t;

    logic               xp_s1_reg, xp_s2_reg;
    tacpd_state_t       st_reg, st_next;
    logic [7:0]         tmr_reg, tmr_next;
    logic [3:0]         bit_reg, bit_next;
    logic [HI_BITS-1:0] code_reg, code_next;
    logic [2:0]         ch_reg, ch_next;
    logic [2:0]         step_reg, step_next;
    logic               rdy_reg, rdy_next;
    logic               pen_reg, pen_next;
    logic               pin_reg, pin_next;
    logic [HI_BITS-1:0] res_reg [7];
    logic               wr_en;
    logic               tick;
    logic [3:0]         top_bit;
    logic [3:0]         stop_bit;
    logic               div_clr;
    logic [2:0]         last_step;

    // Divider restarts with each conversion so its length never depends on phase
    assign div_clr = reset || (st_reg != ST_CONV);

    tacpd_clk_en u_clk_en (
        .core_clk           (core_clk),
        .reset              (div_clr),
        .conv_clock_div_sel (conv_clock_div_sel),
        .conv_tick          (tick)
    );

    always_ff @(posedge core_clk) begin
        xp_s1_reg <= xplus_in;
        xp_s2_reg <= xp_s1_reg;
    end

    assign top_bit  = 4'(HI_BITS - 1);
    assign stop_bit = res_low ? 4'(HI_BITS - LO_BITS) : 4'h0;

    // Channel list per scan mode
    function automatic logic [2:0] step_chan(input logic [1:0] m, input logic [2:0] s,
                                             input logic [2:0] c);
        case (m)
            2'h1:    step_chan = (s == 3'h0) ? `TACPD_CHAN_X : `TACPD_CHAN_Y;
            2'h2:    step_chan = 3'(s);
            2'h3:    step_chan = (s == 3'h0) ? `TACPD_CHAN_TEMP_SINGLE_DIODE : `TACPD_CHAN_TEMP_RATIO_DIODE;
            default: step_chan = c;
        endcase
    endfunction

    always_comb begin
        case (scan_mode)
            2'h1, 2'h3: last_step = 3'h1;
            2'h2:       last_step = 3'h3;
            default:    last_step = 3'h0;
        endcase
    end

    always_comb begin
        st_next   = st_reg;
        tmr_next  = tmr_reg;
        bit_next  = bit_reg;
        code_next = code_reg;
        ch_next   = ch_reg;
        step_next = step_reg;
        wr_en     = 1'b0;
        // idle and sense pen detect on synced X-plus
        pen_next  = (st_reg == ST_IDLE || st_reg == ST_SENSE) ? xp_s2_reg : pen_reg;
        rdy_next  = rdy_reg;
        if (result_ack) begin
            rdy_next = 1'b0;
        end
        case (st_reg)
            ST_IDLE: begin
                if (start) begin
                    step_next = 3'h0;
                    ch_next   = step_chan(scan_mode, 3'h0, chan_sel);
                    tmr_next  = stab_dly;
                    st_next   = ST_STAB;
                end
            end
            ST_STAB: begin
                if (tmr_reg == 8'h00) begin
                    tmr_next = `TACPD_SAMPLE_CYCLES;
                    st_next  = ST_SAMPLE;
                end else begin
                    tmr_next = tmr_reg - 8'h01;
                end
            end
            ST_SAMPLE: begin
                if (tmr_reg == 8'h00) begin
                    bit_next  = top_bit;
                    code_next = '0;
                    code_next[top_bit] = 1'b1;
                    st_next   = ST_CONV;
                end else begin
                    tmr_next = tmr_reg - 8'h01;
                end
            end
            ST_CONV: begin
                if (tick) begin
                    code_next[bit_reg] = comp_in;
                    if (bit_reg == stop_bit) begin
                        st_next = ST_STORE;
                    end else begin
                        bit_next = bit_reg - 4'h1;
                        code_next[bit_reg - 4'h1] = 1'b1;
                    end
                end
            end
            ST_STORE: begin
                wr_en = 1'b1;
                if (step_reg == last_step) begin
                    rdy_next = 1'b1;
                    if (scan_mode == 2'h2) begin
                        tmr_next = prechg_dly;
                        st_next  = ST_PRECHG;
                    end else begin
                        st_next = ST_IDLE;
                    end
                end else begin
                    step_next = step_reg + 3'h1;
                    ch_next   = step_chan(scan_mode, step_reg + 3'h1, chan_sel);
                    tmr_next  = stab_dly;
                    st_next   = ST_STAB;
                end
            end
            ST_PRECHG: begin
                if (tmr_reg == 8'h00) begin
                    tmr_next = sense_dly;
                    st_next  = ST_SENSE;
                end else begin
                    tmr_next = tmr_reg - 8'h01;
                end
            end
            ST_SENSE: begin
                if (tmr_reg == 8'h00) begin
                    st_next = ST_IDLE;
                end else begin
                    tmr_next = tmr_reg - 8'h01;
                end
            end
            default: st_next = ST_IDLE;
        endcase
        pin_next = pin_sel_pen ? pen_next : ~rdy_next;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_reg   <= ST_IDLE;
            tmr_reg  <= 8'h00;
            bit_reg  <= 4'h0;
            code_reg <= '0;
            ch_reg   <= 3'h0;
            step_reg <= 3'h0;
            rdy_reg  <= 1'b0;
            pen_reg  <= 1'b1;
            pin_reg  <= 1'b1;
        end else begin
            st_reg   <= st_next;
            tmr_reg  <= tmr_next;
            bit_reg  <= bit_next;
            code_reg <= code_next;
            ch_reg   <= ch_next;
            step_reg <= step_next;
            rdy_reg  <= rdy_next;
            pen_reg  <= pen_next;
            pin_reg  <= pin_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < 7; i++) begin
                res_reg[i] <= '0;
            end
        end else if (wr_en) begin
            res_reg[ch_reg] <= res_low ? (code_reg >> (HI_BITS - LO_BITS)) : code_reg;
        end
    end

    logic pull_reg, ygnd_reg, pre_reg, samp_reg, filt_reg, busy_reg;
    logic [2:0] mux_reg;
    logic [HI_BITS-1:0] dac_reg;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pull_reg <= 1'b1;
            ygnd_reg <= 1'b1;
            pre_reg  <= 1'b0;
            samp_reg <= 1'b0;
            filt_reg <= 1'b0;
            busy_reg <= 1'b0;
            mux_reg  <= 3'h0;
            dac_reg  <= '0;
        end else begin
            pull_reg <= (st_next == ST_IDLE || st_next == ST_PRECHG || st_next == ST_SENSE);
            ygnd_reg <= (st_next == ST_IDLE || st_next == ST_SENSE);
            pre_reg  <= (st_next == ST_PRECHG);
            samp_reg <= (st_next == ST_SAMPLE);
            filt_reg <= filter_en;
            busy_reg <= (st_next != ST_IDLE);
            mux_reg  <= ch_next;
            dac_reg  <= code_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 7; g++) begin : g_res
            assign results[g*HI_BITS +: HI_BITS] = res_reg[g];
        end
    endgenerate

    assign pull_up_on        = pull_reg;
    assign yminus_gnd        = ygnd_reg;
    assign prechg_on         = pre_reg;
    assign sample_on         = samp_reg;
    assign mux_sel           = mux_reg;
    assign dac_code          = dac_reg;
    assign filter_on         = filt_reg;
    assign busy              = busy_reg;
    assign result_ready_flag = rdy_reg;
    assign pen_touch_irq     = pen_reg;
    assign irq_status_pin    = pin_reg;

    property p_pullup_off;
        @(posedge core_clk) disable iff (reset)
        (st_reg == ST_CONV) |-> !pull_up_on;
    endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pull-up on while converting");

    property p_ready_set;
        @(posedge core_clk) disable iff (reset)
        (st_reg == ST_STORE && step_reg == last_step) |=> result_ready_flag;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready flag not set");

    property p_pin_mode;
        @(posedge core_clk) disable iff (reset)
        pin_sel_pen && $stable(pin_sel_pen) |-> irq_status_pin == pen_touch_irq;
    endproperty
    a_pin_mode: assert property (p_pin_mode) else $error("status pin source wrong");

    property p_sample_len;
        @(posedge core_clk) disable iff (reset)
        (st_reg == ST_STAB && st_next == ST_SAMPLE) |=> (st_reg == ST_SAMPLE) [*7];
    endproperty
    a_sample_len: assert property (p_sample_len) else $error("sample time wrong");

    sequence s_scan_req;
        st_reg == ST_IDLE && start;
    endsequence

    property p_scan_start;
        @(posedge core_clk) disable iff (reset)
        s_scan_req |=> busy && st_reg == ST_STAB;
    endproperty
    a_scan_start: assert property (p_scan_start) else $error("start not taken");

    property p_ack_clear;
        @(posedge core_clk) disable iff (reset)
        (result_ack && !(st_reg == ST_STORE && step_reg == last_step)) |=> !result_ready_flag;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("ready flag not cleared");
endmodule
`default_nettype wire

// ==== tacpd_panel_model.sv ====
// Touch panel and analog front end model facing the converter block
`timescale 1ns/1ns
`default_nettype none

module tacpd_panel_model (
    input  wire logic        core_clk,   // Oscillator
    input  wire logic        touched,    // Pen on the panel
    input  wire logic [83:0] levels,     // Input level per channel
    input  wire logic [2:0]  mux_sel,    // Selected channel
    input  wire logic [11:0] dac_code,   // Trial code
    input  wire logic        pull_up_on, // Pull-up connected
    input  wire logic        yminus_gnd, // Y-minus grounded
    output logic             comp_in,    // Keep trial bit
    output logic             xplus_in    // X-plus level
);
    logic toggle = 1'b0;

    // Floating pin shows a changing pattern, never a held value
    always @(posedge core_clk) begin
        toggle <= ~toggle;
    end

    assign comp_in = (dac_code <= levels[mux_sel*12 +: 12]);

    assign xplus_in = !pull_up_on ? toggle : !(touched && yminus_gnd);
endmodule

`default_nettype wire

// ==== tacpd_core_tb.sv ====
// Self-checking bench for the touch converter control block
`timescale 1ns/1ns
`default_nettype none
`include "tacpd_defs.svh"

module tacpd_core_tb;
    typedef struct {
        logic [2:0]  chan;
        logic        lo;
        logic [1:0]  div;
        logic [7:0]  stab;
        logic [11:0] level;
    } tacpd_row_t;

    // 12 bit only at 01 or 10
    tacpd_row_t rows [7] = '{
        '{`TACPD_CHAN_X,     1'h0, `TACPD_DIV_TWO,   8'h03, 12'hA5C},
        '{`TACPD_CHAN_Y,     1'h0, `TACPD_DIV_FOUR,  8'h00, 12'h000},
        '{`TACPD_CHAN_Z1,    1'h1, `TACPD_DIV_NONE,  8'h05, 12'hFFF},
        '{`TACPD_CHAN_Z2,    1'h1, `TACPD_DIV_EIGHT, 8'h02, 12'h3C7},
        '{`TACPD_CHAN_TEMP_SINGLE_DIODE, 1'h0, `TACPD_DIV_TWO,   8'h00, 12'hFFF},
        '{`TACPD_CHAN_TEMP_RATIO_DIODE, 1'h1, `TACPD_DIV_FOUR,  8'h01, 12'h801},
        '{`TACPD_CHAN_AUX,   1'h0, `TACPD_DIV_FOUR,  8'h04, 12'h001}
    };

    logic        core_clk = 1'b0, reset = 1'b1, start = 1'b0, filter_en = 1'b0;
    logic        res_low = 1'b0, pin_sel_pen = 1'b0, result_ack = 1'b0, touched = 1'b0;
    logic [2:0]  chan_sel = 3'h0;
    logic [1:0]  scan_mode = 2'h0, conv_clock_div_sel = 2'h1;
    logic [7:0]  stab_dly = 8'h00, prechg_dly = 8'h03, sense_dly = 8'h02;
    logic [83:0] levels = 84'h0;
    logic        comp_in, xplus_in, pull_up_on, yminus_gnd, prechg_on, sample_on;
    logic        filter_on, busy, result_ready_flag, pen_touch_irq, irq_status_pin;
    logic [2:0]  mux_sel;
    logic [11:0] dac_code;
    logic [83:0] results;
    int          num_errors = 0, check_count = 0, pc = 0;
    int          dur, off, off0, d0;
    int          durs [3], pcs [3];

    always #2 core_clk = ~core_clk;

    tacpd_core uut (
        .core_clk(core_clk), .reset(reset), .start(start), .chan_sel(chan_sel),
        .scan_mode(scan_mode), .filter_en(filter_en), .res_low(res_low),
        .conv_clock_div_sel(conv_clock_div_sel), .stab_dly(stab_dly),
        .prechg_dly(prechg_dly), .sense_dly(sense_dly), .pin_sel_pen(pin_sel_pen),
        .result_ack(result_ack), .comp_in(comp_in), .xplus_in(xplus_in),
        .pull_up_on(pull_up_on), .yminus_gnd(yminus_gnd), .prechg_on(prechg_on),
        .sample_on(sample_on), .mux_sel(mux_sel), .dac_code(dac_code),
        .filter_on(filter_on), .busy(busy), .result_ready_flag(result_ready_flag),
        .pen_touch_irq(pen_touch_irq), .irq_status_pin(irq_status_pin), .results(results)
    );

    tacpd_panel_model panel (
        .core_clk(core_clk), .touched(touched), .levels(levels), .mux_sel(mux_sel),
        .dac_code(dac_code), .pull_up_on(pull_up_on), .yminus_gnd(yminus_gnd),
        .comp_in(comp_in), .xplus_in(xplus_in)
    );

    task automatic check(string name, logic [83:0] seen, logic [83:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (num_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Start one scan, optionally retry start mid-scan, count cycles to idle
    task automatic run_scan(input logic again, output int n);
        @(posedge core_clk);
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        n = 1;
        #1;
        check("busy", busy, 1'b1);
        while (busy !== 1'b0 && n < 4000) begin
            @(posedge core_clk);
            start <= (again && n == 5);
            #1;
            n++;
        end
        if (n >= 4000) begin
            num_errors++;
            give_verdict();
        end
    endtask

    task automatic ack_check();
        check("ready set", result_ready_flag, 1'b1);
        check("pin ready", irq_status_pin, 1'b0);
        @(posedge core_clk);
        result_ack <= 1'b1;
        @(posedge core_clk);
        result_ack <= 1'b0;
        @(posedge core_clk);
        #1;
        check("ready clear", result_ready_flag, 1'b0);
        check("pin idle", irq_status_pin, 1'b1);
    endtask

    always @(posedge core_clk) begin
        if (!reset && sample_on && mux_sel inside {`TACPD_CHAN_X, `TACPD_CHAN_Y})
            check("pull_up_on meas", pull_up_on, 1'b0);
        if (prechg_on) begin
            pc++;
            check("pull_up_on prechg", pull_up_on, 1'b1);
        end
    end

    initial begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        check("reset outs", {pull_up_on, yminus_gnd, pen_touch_irq, irq_status_pin},
              4'hF);
        check("reset idle", {busy, result_ready_flag, prechg_on, sample_on}, 4'h0);
        check("reset results", results, 84'h0);
        for (int i = 0; i < 7; i++) begin
            @(posedge core_clk);
            chan_sel <= rows[i].chan;
            res_low <= rows[i].lo;
            conv_clock_div_sel <= rows[i].div;
            stab_dly <= rows[i].stab;
            levels[rows[i].chan*12 +: 12] <= rows[i].level;
            run_scan(1'b0, dur);
            check("result", results[rows[i].chan*12 +: 12],
                  rows[i].lo ? rows[i].level >> 2 : rows[i].level);
            off = dur - rows[i].stab - (rows[i].lo ? 10 : 12) * (1 << rows[i].div);
            if (i == 0)
                off0 = off;
            if (i == 0)
                d0 = dur;
            check("conv time", off, off0);
            ack_check();
        end
        // Repeat the first row with a start pulse during the scan
        @(posedge core_clk);
        chan_sel <= rows[0].chan;
        res_low <= rows[0].lo;
        conv_clock_div_sel <= rows[0].div;
        stab_dly <= rows[0].stab;
        run_scan(1'b1, dur);
        check("refused start time", dur, d0);
        repeat (3) @(posedge core_clk);
        #1;
        check("refused start idle", busy, 1'b0);
        ack_check();
        // Coordinate pair, then the full touch scan with timed recheck
        @(posedge core_clk);
        scan_mode <= tacpd_pkg::TACPD_SCAN_XY;
        res_low <= 1'b0;
        conv_clock_div_sel <= `TACPD_DIV_TWO;
        stab_dly <= 8'h00;
        levels[23:0] <= {12'hCDE, 12'h321};
        touched <= 1'b1;
        run_scan(1'b0, dur);
        check("xy results", results[23:0], {12'hCDE, 12'h321});
        @(posedge core_clk);
        scan_mode <= tacpd_pkg::TACPD_SCAN_XYZ;
        levels[47:0] <= {12'h9AB, 12'h456, 12'h7F0, 12'h10F};
        for (int k = 0; k < 3; k++) begin
            @(posedge core_clk);
            prechg_dly <= (k == 0) ? 8'h03 : 8'h09;
            sense_dly <= (k == 2) ? 8'h07 : 8'h02;
            pc = 0;
            run_scan(1'b0, durs[k]);
            pcs[k] = pc;
        end
        check("xyz results", results[47:0], {12'h9AB, 12'h456, 12'h7F0, 12'h10F});
        check("prechg count", pcs[1] - pcs[0], 6);
        check("prechg time", durs[1] - durs[0], 6);
        check("sense time", durs[2] - durs[1], 5);
        // Two-diode temperature scan with preprocessing on
        @(posedge core_clk);
        scan_mode <= tacpd_pkg::TACPD_SCAN_TEMP_DIFF;
        filter_en <= 1'b1;
        levels[71:48] <= {12'h456, 12'h123};
        run_scan(1'b0, dur);
        check("temp results", results[71:48], {12'h456, 12'h123});
        check("filter on", filter_on, 1'b1);
        // Idle touch detect routed to the status pin
        @(posedge core_clk);
        pin_sel_pen <= 1'b1;
        filter_en <= 1'b0;
        repeat (6) @(posedge core_clk);
        #1;
        check("touch", {yminus_gnd, pen_touch_irq, irq_status_pin}, 3'h4);
        @(posedge core_clk);
        touched <= 1'b0;
        repeat (6) @(posedge core_clk);
        #1;
        check("release", {pen_touch_irq, irq_status_pin}, 2'h3);
        // Reset in the middle of a scan
        @(posedge core_clk);
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        repeat (4) @(posedge core_clk);
        reset <= 1'b1;
        @(posedge core_clk);
        reset <= 1'b0;
        #1;
        check("mid reset", {busy, result_ready_flag, pull_up_on}, 3'h1);
        check("mid reset results", results, 84'h0);
        give_verdict();
    end
endmodule

`default_nettype wire
